/* hw/pmpc_pkg.sv */
// Package of offsets, field positions and reset values for the power/PHY control registers
//
// Contract
// R1 - Power control/status register keeps contents across the D3hot-to-D0 internal reset.
// R2 - Wake-event status sets on any wake event, whatever the enable bit says.
// R3 - Writing 1 clears wake-event status and drops the wake output; 0 does nothing.
// R4 - Data-scale bits 14-13 and data-select bits 12-9 always read zero.
// R5 - Wake output asserts only while wake-event enable bit 8 is one.
// R6 - Enable resets to 0 without cold wake support; sticky with it, software clears.
// R7 - Two-bit power-state field is read/write: 00 D0, 01 D1, 10 D2, 11 D3.
// R8 - Reserved bits 7-2 of power control/status read as zero.
// R9 - Power extension register is read-only, all sixteen bits zero.
// R10 - Routing bit 7 set drives the cable-activity indicator onto its own pin.
// R11 - With an EEPROM present, routing bit loads from bit 7 of byte 16h.
// R12 - PHY control bit 3 is read-only and defaults to one.
// R13 - EEPROM programmer sets bit 3 of byte 16h to one.
// R14 - EEPROM programmer writes zeros to bits 6-4 and 2-0 of byte 16h.
// R15 - PHY control bits 31-8 read zero; reset value is 0x00000008.
// R16 - Cold wake support comes from a ROM-loaded configuration bit.
// R17 - Sticky wake bits are cleared only by power-on reset, not bus reset.
package pmpc_pkg;
    localparam logic [7:0]  PMPC_OFF_PWR_CTRL_STATUS = 8'h48;
    localparam logic [7:0]  PMPC_OFF_PWR_EXTENSION   = 8'h4A;
    localparam logic [7:0]  PMPC_OFF_PHY_OUTPUT_CTRL = 8'hEC;
    localparam int          PMPC_BIT_WAKE_STATUS     = 15;
    localparam int          PMPC_BIT_WAKE_ENABLE     = 8;
    localparam int          PMPC_BIT_CABLE_ROUTE     = 7;
    localparam int          PMPC_BIT_COMPLIANCE      = 3;
    localparam logic [7:0]  PMPC_EEPROM_PHY_BYTE     = 8'h16;
    localparam logic [1:0]  PMPC_POWER_STATE_FIELD_RESET     = 2'h0;
    localparam logic [15:0] PMPC_PWR_EXT_VALUE       = 16'h0000;
    localparam logic [31:0] PMPC_PHY_CTRL_RESET      = 32'h00000008;
    // Power states
    typedef enum logic [1:0] {
        PMPC_D0 = 2'h0,
        PMPC_D1 = 2'h1,
        PMPC_D2 = 2'h2,
        PMPC_D3 = 2'h3
    } pmpc_pstate_e;
endpackage

/* hw/pmpc_cfg_if.sv */
// Interface carrying the configuration access between top and register core
`timescale 1ns/1ps
interface pmpc_cfg_if;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        hit;
    modport master (output wr, rd, addr, wdata, be, input rdata, hit);
    modport slave  (input wr, rd, addr, wdata, be, output rdata, hit);
endinterface

/* hw/pmpc_wake_core.sv */
// Wake-event status/enable bits held on the power-on reset domain
`timescale 1ns/1ps
module pmpc_wake_core
    import pmpc_pkg::*;
(
    // Clock and resets
    input  wire logic mclk,
    input  wire logic por_reset,
    input  wire logic reset,
    // Control
    input  wire logic cold_wake_support,
    input  wire logic wake_event,
    input  wire logic enable_wr,
    input  wire logic enable_wdata,
    input  wire logic status_clr,
    // State
    output logic      wake_event_status_q,
    output logic      wake_event_enable_q
);
    logic wake_event_status_d;
    logic wake_event_enable_d;

    // Set beats the write-one clear in the same cycle
    always_comb begin
        wake_event_status_d = wake_event_status_q;
        if (status_clr) begin
            wake_event_status_d = 1'b0;                      // see R3
        end
        if (wake_event) begin
            wake_event_status_d = 1'b1;                      // see R2
        end
        wake_event_enable_d = enable_wr ? enable_wdata : wake_event_enable_q;
        // Bus reset clears enable only without cold wake support
        if (reset && !cold_wake_support) begin
            wake_event_enable_d = 1'b0;                      // see R6
        end
    end

    // Only power-on reset touches these asynchronously
    always_ff @(posedge mclk or posedge por_reset) begin
        if (por_reset) begin
            wake_event_status_q <= 1'b0;                     // see R17
            wake_event_enable_q <= 1'b0;
        end else begin
            wake_event_status_q <= wake_event_status_d;
            wake_event_enable_q <= wake_event_enable_d;
        end
    end
endmodule

/* hw/pmpc_regs.sv */
// Power management control/status, extension and PHY output control registers
`timescale 1ns/1ps
module pmpc_regs
    import pmpc_pkg::*;
(
    // Clock and resets
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        por_reset,
    input  wire logic        d3hot_reset,
    // Configuration access
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  cfg_be,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_hit,
    // EEPROM preload
    input  wire logic        eeprom_load,
    input  wire logic [7:0]  eeprom_byte,
    input  wire logic [7:0]  eeprom_data,
    // ROM-loaded capability
    input  wire logic        cold_wake_support,
    // Wake and PHY signals
    input  wire logic        wake_event,
    output logic             wake_out,
    output logic [1:0]       power_state_field,
    input  wire logic        cable_activity_indicator,
    output logic             cable_activity_out,
    output logic             cable_activity_out_en
);
    pmpc_cfg_if cfg ();

    logic [1:0]  power_state_q;
    logic [1:0]  power_state_d;
    logic        cable_activity_route_q;
    logic        cable_activity_route_d;
    logic        cable_out_q;
    logic        cable_out_en_q;
    logic        cable_out_d;
    logic        cable_out_en_d;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        wake_status;
    logic        wake_enable;
    logic        sel_pcs;
    logic        sel_phy;

    // Word-aligned address decode, used for write and read paths
    function automatic logic sel_word(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    assign cfg.wr    = cfg_wr;
    assign cfg.rd    = cfg_rd;
    assign cfg.addr  = cfg_addr;
    assign cfg.wdata = cfg_wdata;
    assign cfg.be    = cfg_be;
    assign cfg_rdata = cfg.rdata;
    assign cfg_hit   = cfg.hit;

    assign sel_pcs = cfg.wr && sel_word(cfg.addr, PMPC_OFF_PWR_CTRL_STATUS);
    assign sel_phy = cfg.wr && sel_word(cfg.addr, PMPC_OFF_PHY_OUTPUT_CTRL);

    // Sticky wake bits live in their own reset domain; d3hot reset never reaches them
    pmpc_wake_core u_wake (
        .mclk                (mclk),
        .por_reset           (por_reset),
        .reset               (reset),
        .cold_wake_support   (cold_wake_support),                          // see R16
        .wake_event          (wake_event),
        .enable_wr           (sel_pcs && cfg.be[1]),
        .enable_wdata        (cfg.wdata[PMPC_BIT_WAKE_ENABLE]),
        .status_clr          (sel_pcs && cfg.be[1] && cfg.wdata[PMPC_BIT_WAKE_STATUS]), // see R3
        .wake_event_status_q (wake_status),
        .wake_event_enable_q (wake_enable)
    );

    // Wake output follows status gated by enable; clearing status drops it
    assign wake_out          = wake_status && wake_enable;                   // see R5
    assign power_state_field = power_state_q;

    // Next state: power-state and cable routing
    always_comb begin
        power_state_d          = power_state_q;
        cable_activity_route_d = cable_activity_route_q;
        if (sel_pcs && cfg.be[0]) begin
            power_state_d = cfg.wdata[1:0];                                  // see R7
        end
        if (sel_phy && cfg.be[0]) begin
            cable_activity_route_d = cfg.wdata[PMPC_BIT_CABLE_ROUTE];
        end
        // EEPROM preload wins over a concurrent write
        if (eeprom_load && eeprom_byte == PMPC_EEPROM_PHY_BYTE) begin
            cable_activity_route_d = eeprom_data[PMPC_BIT_CABLE_ROUTE];      // see R11
        end
        // PHY control is an ordinary function register, cleared by d3hot reset too
        if (d3hot_reset) begin
            cable_activity_route_d = PMPC_PHY_CTRL_RESET[PMPC_BIT_CABLE_ROUTE];
        end
    end

    // Power-state survives d3hot reset: only bus reset clears it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            power_state_q <= PMPC_POWER_STATE_FIELD_RESET;                           // see R1
        end else begin
            power_state_q <= power_state_d;
        end
    end

    // Cable routing register; the d3hot clear is folded into its next value
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cable_activity_route_q <= PMPC_PHY_CTRL_RESET[PMPC_BIT_CABLE_ROUTE];
        end else begin
            cable_activity_route_q <= cable_activity_route_d;
        end
    end

    // Read mux: reserved fields tie to zero; data holds between reads
    always_comb begin
        rdata_d = rdata_q;
        if (cfg.rd) begin
            rdata_d = 32'h00000000;
            if (sel_word(cfg.addr, PMPC_OFF_PWR_CTRL_STATUS)) begin
                rdata_d[PMPC_BIT_WAKE_STATUS] = wake_status;                 // see R4, R8
                rdata_d[PMPC_BIT_WAKE_ENABLE] = wake_enable;
                rdata_d[1:0]                  = power_state_q;
                rdata_d[31:16]                = PMPC_PWR_EXT_VALUE;          // see R9
            end else if (sel_word(cfg.addr, PMPC_OFF_PHY_OUTPUT_CTRL)) begin
                rdata_d[PMPC_BIT_CABLE_ROUTE] = cable_activity_route_q;      // see R15
                rdata_d[PMPC_BIT_COMPLIANCE]  = PMPC_PHY_CTRL_RESET[PMPC_BIT_COMPLIANCE]; // see R12
            end
        end
    end

    // Cable pin next values; registered so the pin never glitches on a route write
    always_comb begin
        cable_out_d    = cable_activity_route_q && cable_activity_indicator; // see R10
        cable_out_en_d = cable_activity_route_q;
    end

    assign cfg.hit = sel_word(cfg.addr, PMPC_OFF_PWR_CTRL_STATUS) ||
                     sel_word(cfg.addr, PMPC_OFF_PHY_OUTPUT_CTRL);
    assign cfg.rdata = rdata_q;

    // Registered read data and cable pin
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_q        <= 32'h00000000;
            cable_out_q    <= 1'b0;
            cable_out_en_q <= 1'b0;
        end else begin
            rdata_q        <= rdata_d;
            cable_out_q    <= cable_out_d;
            cable_out_en_q <= cable_out_en_d;
        end
    end

    assign cable_activity_out    = cable_out_q;
    assign cable_activity_out_en = cable_out_en_q;
endmodule

/* dv/pmpc_regs_monitor.sv */
// Assertion checker for the power/PHY control registers
`timescale 1ns/1ps
module pmpc_regs_monitor (
    // Clock and resets
    input wire logic mclk, reset, por_reset, d3hot_reset,
    // Access
    input wire logic cfg_wr, cfg_rd, cfg_hit,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata, cfg_rdata,
    input wire logic [3:0] cfg_be,
    // Wake and PHY
    input wire logic wake_event, wake_out, cable_activity_indicator,
    input wire logic cable_activity_out, cable_activity_out_en,
    input wire logic [1:0] power_state_field
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset || por_reset);
    // Accesses to the control/status word
    sequence s_wr48; cfg_wr && cfg_addr[7:2] == 6'h12; endsequence
    sequence s_rd48; cfg_rd && !cfg_wr && cfg_addr[7:2] == 6'h12; endsequence
    property p_unmapped; cfg_rd && !cfg_hit |=> cfg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_pm_zero; s_rd48 |=> (cfg_rdata & 32'hFFFF_7EFC) == 32'h0; endproperty
    a_pm_zero: assert property (p_pm_zero) else $error("zero bits set");
    property p_phy; cfg_rd && cfg_addr == 8'hEC |=> (cfg_rdata & 32'hFFFF_FF7F) == 32'h8; endproperty
    a_phy: assert property (p_phy) else $error("phy fixed bits");
    property p_pstate; s_wr48 ##0 cfg_be[0] |=> power_state_field == $past(cfg_wdata[1:0]); endproperty
    a_pstate: assert property (p_pstate) else $error("power state");
    property p_d3hot; d3hot_reset && !cfg_wr && !wake_event |=> $stable({power_state_field, wake_out}); endproperty
    a_d3hot: assert property (p_d3hot) else $error("d3hot changed");
    property p_w1c; s_wr48 ##0 cfg_be[1] && cfg_wdata[15] && !wake_event |=> !wake_out; endproperty
    a_w1c: assert property (p_w1c) else $error("wake not cleared");
    property p_en_off; s_wr48 ##0 cfg_be[1] && !cfg_wdata[8] |=> !wake_out; endproperty
    a_en_off: assert property (p_en_off) else $error("wake while off");
    property p_status; wake_event ##1 !cfg_wr ##1 s_rd48 |=> cfg_rdata[15]; endproperty
    a_status: assert property (p_status) else $error("status not set");
    property p_cable; cable_activity_out == ($past(cable_activity_indicator) && cable_activity_out_en); endproperty
    a_cable: assert property (p_cable) else $error("cable output");
    property p_hit; cfg_hit == (cfg_addr[7:2] == 6'h12 || cfg_addr[7:2] == 6'h3B); endproperty
    a_hit: assert property (p_hit) else $error("hit decode");
endmodule
bind pmpc_regs pmpc_regs_monitor i_pmpc_regs_monitor (
    .mclk (mclk), .reset (reset), .por_reset (por_reset), .d3hot_reset (d3hot_reset),
    .cfg_wr (cfg_wr), .cfg_rd (cfg_rd), .cfg_hit (cfg_hit), .cfg_addr (cfg_addr),
    .cfg_wdata (cfg_wdata), .cfg_rdata (cfg_rdata), .cfg_be (cfg_be), .wake_event (wake_event),
    .wake_out (wake_out), .cable_activity_indicator (cable_activity_indicator),
    .cable_activity_out (cable_activity_out), .cable_activity_out_en (cable_activity_out_en),
    .power_state_field (power_state_field)
);

/* dv/pmpc_host_model.sv */
// Host bridge model: configuration cycles and EEPROM preload
`timescale 1ns/1ps
module pmpc_host_model (
    // Clock and read data
    input wire logic mclk,
    input wire logic [31:0] cfg_rdata,
    // Access and preload
    output logic cfg_wr, cfg_rd, eeprom_load,
    output logic [7:0] cfg_addr, eeprom_byte, eeprom_data,
    output logic [31:0] cfg_wdata,
    output logic [3:0] cfg_be
);
    // Quiet until the first request
    initial {cfg_wr, cfg_rd, eeprom_load, cfg_addr, eeprom_byte, eeprom_data, cfg_wdata, cfg_be} = '0;
    // Held over one edge; on release strobes drop, address and data inverted so stale data never passes
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk) #1;
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {wr, !wr, a, be, d};
        @(posedge mclk) #1;
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'h0, ~a, ~d};
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] q);
        access(1'b0, a, 4'hF, 32'h0);
        q = cfg_rdata;
    endtask
    // Image byte keeps compliance bit one, reserved bits zero
    task automatic preload(input logic route);
        @(posedge mclk) #1;
        {eeprom_load, eeprom_byte, eeprom_data} = {1'b1, 8'h16, route, 7'h08};
        @(posedge mclk) #1;
        {eeprom_load, eeprom_byte, eeprom_data} = {1'b0, 8'hE9, ~route, 7'h77};
    endtask
endmodule

/* dv/test_pmpc_regs.sv */
// Self-checking testbench for the power/PHY control registers
`timescale 1ns/1ps
module test_pmpc_regs;
    import pmpc_pkg::*;
    logic mclk, reset, por_reset, d3hot_reset, cfg_wr, cfg_rd, cfg_hit, eeprom_load, cold_wake_support;
    logic wake_event, wake_out, cable_activity_indicator, cable_activity_out, cable_activity_out_en;
    logic [7:0] cfg_addr, eeprom_byte, eeprom_data;
    logic [31:0] cfg_wdata, cfg_rdata, q;
    logic [3:0] cfg_be;
    logic [1:0] power_state_field;
    int n_fail = 0;
    int total_checks = 0;
    typedef struct {logic [7:0] wa; logic [3:0] be; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} pmpc_row_s;
    // Write, read back; fixed-zero bits written as ones
    pmpc_row_s rows [5] = '{
        '{8'h48, 4'h3, 32'h0000_7FFF, 8'h48, 32'h0000_0103},
        '{8'h48, 4'hF, 32'hFFFF_0002, 8'h4A, 32'h0000_0002},
        '{8'h48, 4'h1, 32'h0000_00FC, 8'h48, 32'h0000_0000},
        '{8'hEC, 4'hF, 32'hFFFF_FFFF, 8'hEC, 32'h0000_0088},
        '{8'h50, 4'hF, 32'hFFFF_FFFF, 8'h50, 32'h0000_0000}};
    pmpc_regs i_pmpc_regs (.*);
    pmpc_host_model i_pmpc_host_model (.*);
    // 200 MHz clock; toggling indicator for the routed output
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) cable_activity_indicator <= #1 (reset ? 1'b0 : ~cable_activity_indicator);
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
        total_checks++;
        if (seen !== ex) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, ex);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] ex);
        i_pmpc_host_model.read(a, q);
        chk(q, ex);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        i_pmpc_host_model.access(1'b1, a, be, d);
    endtask
    task automatic rst(input logic [1:0] v);
        {reset, por_reset} = v;
        repeat (2) @(posedge mclk);
        #1 {reset, por_reset} = 2'h0;
    endtask
    task automatic end_of_test();
        $display("total_checks=%0d n_fail=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {reset, por_reset, d3hot_reset, cold_wake_support, wake_event} = 5'h18;
        repeat (6) @(posedge mclk);
        #1 {reset, por_reset} = 2'h0;
        rc(8'hEC, 32'h8);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].be, rows[i].wd);
            rc(rows[i].ra, rows[i].ex);
        end
        // Routed pin shows the indicator one edge late, after the indicator has moved on
        #1 chk({31'h0, cable_activity_out}, {31'h0, ~cable_activity_indicator});
        @(posedge mclk) #1 chk({31'h0, cable_activity_out_en}, 32'h1);
        // Status sets with enable off
        wake_event = 1'b1;
        @(posedge mclk) #1 wake_event = 1'b0;
        chk({31'h0, wake_out}, 32'h0);
        rc(8'h48, 32'h8000);
        wr(8'h48, 4'h2, 32'h0100);
        chk({31'h0, wake_out}, 32'h1);
        wr(8'h48, 4'h1, 32'h1);
        // D3hot internal reset leaves control/status alone
        d3hot_reset = 1'b1;
        @(posedge mclk) #1 d3hot_reset = 1'b0;
        rc(8'h48, 32'h8101);
        chk({30'h0, power_state_field}, 32'h1);
        // Wake event in the clearing cycle: set wins; enable off then drops the output
        fork
            wr(8'h48, 4'h2, 32'h8100);
            begin
                @(posedge mclk) #1 wake_event = 1'b1;
                @(posedge mclk) #1 wake_event = 1'b0;
            end
        join
        chk({31'h0, wake_out}, 32'h1);
        wr(8'h48, 4'h2, 32'h0000);
        chk({31'h0, wake_out}, 32'h0);
        rc(8'h48, 32'h8001);
        wr(8'h48, 4'h2, 32'h8100);
        rc(8'h48, 32'h0101);
        chk({31'h0, wake_out}, 32'h0);
        i_pmpc_host_model.preload(1'b1);
        rc(8'hEC, 32'h88);
        i_pmpc_host_model.preload(1'b0);
        rc(8'hEC, 32'h8);
        // Enable sticky over bus reset only with cold wake support
        cold_wake_support = 1'b1;
        rst(2'h2);
        rc(8'h48, 32'h0100);
        rst(2'h3);
        rc(8'h48, 32'h0);
        wr(8'h48, 4'h2, 32'h0100);
        cold_wake_support = 1'b0;
        rst(2'h2);
        rc(8'h48, 32'h0);
        end_of_test();
    end
    // Hang guard
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end
endmodule
